// File: rtl/trace_ctl_pkg.sv
// Purpose: shared constants for the trace trigger and filter control block
// Assumes: 32-bit APB, word-aligned registers
// Notes: offsets are byte addresses
package trace_ctl_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_EXTOUT_EV = 12'h008;
  localparam logic [11:0] OFF_FIFO_LVL = 12'h00C;
  localparam logic [11:0] OFF_PTAG = 12'h010;
  // control register fields
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_PTAG_EN = 1;
  localparam int CTRL_SUPP_EN = 2;
  localparam int CTRL_CYC_EN = 3;
  localparam int CTRL_DATA_ONLY = 4;
  localparam int CTRL_WFX_PROHIB = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [7:0] FIFO_LVL_RESET = 8'h10;
  // resource number of the trace-prohibited resource
  localparam logic [6:0] RES_PROHIBITED = 7'b110_1110;
  localparam logic [31:0] PROHIB_TARGET = 32'h0000_0000;
  localparam int MIN_GAP_CYCLES = 2;
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_ADDR = 2'b01,
    SYNC_PTAG = 2'b10,
    SYNC_PROHIB = 2'b11
  } sync_state_t;
endpackage

// File: rtl/trace_event_unit.sv
// Purpose: one programmable event: two resources combined by and/or with optional inversion
// Assumes: resource inputs are already synchronous to pclk
// Notes: config layout [6:0] res a, [13:7] res b, [14] inv a, [15] inv b, [16] or
`timescale 1ns/1ps
module trace_event_unit #(
  parameter int NRES = 128
) (
  input wire logic [NRES-1:0] resources,
  input wire logic [16:0] cfg,
  output logic hit
);
  initial begin
    if (NRES != 128) $error("resource vector must be 128 wide");
  end
  logic a;
  logic b;
  always_comb begin
    a = resources[cfg[6:0]] ^ cfg[14];
    b = resources[cfg[13:7]] ^ cfg[15];
    hit = cfg[16] ? (a | b) : (a & b);
  end
endmodule

// File: rtl/trace_filter_ctl.sv
// Purpose: trigger, external outputs and trace gating for the trace unit
// Assumes: processor status inputs are synchronous; prohibit pins pass a synchroniser
// Notes: comparator, counter, sequencer and packet encoders are outside
// Operation
// - only one trigger per trace run
// - trigger never alters trace generation
// - up to four external outputs, each from its own event; code loads only 32 config bits, so outputs 2 and 3 keep an all-zero event
// - external outputs low while the hold bit is set
// - on re-enable emit full address, plus process tag if enabled
// - too-short trace gaps may be traced through
// - data view gate qualifies data, only while trace gate is high
// - suppression stops data tracing when buffer exceeds the level
// - tracing needs gate and no debug, wait, overflow or prohibition
// - new process or guest tag not sent on prohibited entry
// - after entry packet tracing stops inside the region
// - outstanding out-of-order data still traced when it returns
// - cycle counter keeps counting in prohibited regions
// - instruction comparators never match in prohibited regions
// - data comparators ignore region transfers; range match held
// - process-tag comparators report no match in prohibited regions
// - instrumentation has no effect in prohibited regions
// - resources work normally there; prohibited resource provided
// - dynamic prohibit entry and exit may lag
// - non-secure resource low inside prohibited non-secure region
// - trigger placed on port as soon as possible
// - trace gate falls only at instruction boundary when tracing instructions
`timescale 1ns/1ps
module trace_filter_ctl
  import trace_ctl_pkg::*;
#(
  parameter int NUM_EXTOUT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] resources_in,
  input wire logic [16:0] trigger_ev_cfg,
  input wire logic [16:0] gate_ev_cfg,
  input wire logic [16:0] view_ev_cfg,
  input wire logic instr_boundary,
  input wire logic data_outstanding,
  input wire logic debug_state,
  input wire logic wait_for_interrupt_state,
  input wire logic wait_for_event_state,
  input wire logic buffer_overflow,
  input wire logic [7:0] buffer_level,
  input wire logic prohibit_pin,
  input wire logic nonsecure_in,
  input wire logic exception_entry,
  input wire logic [3:0] exception_type,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] process_tag_in,
  input wire logic iaddr_match_raw,
  input wire logic daddr_match_raw,
  input wire logic drange_match_raw,
  input wire logic ptag_match_raw,
  input wire logic instrument_req,
  input wire logic ooo_data_return,
  input wire logic cycle_tick,
  output logic trigger_out,
  output logic [NUM_EXTOUT-1:0] ext_out,
  output logic tracing,
  output logic trace_gate,
  output logic data_view_gate,
  output logic data_trace_en,
  output logic ooo_data_en,
  output logic sync_valid,
  output logic [1:0] sync_kind,
  output logic [31:0] sync_payload,
  output logic [3:0] sync_exc,
  output logic sync_hyp,
  output logic iaddr_match,
  output logic daddr_match,
  output logic drange_match,
  output logic ptag_match,
  output logic instrument_fire,
  output logic nonsecure_res,
  output logic [15:0] cycle_count
);
  initial begin
    if (NUM_EXTOUT < 1 || NUM_EXTOUT > 4) $error("NUM_EXTOUT must be 1..4");
  end

  logic [31:0] ctrl_q;
  logic [NUM_EXTOUT*17-1:0] extout_cfg_q;
  logic [7:0] fifo_lvl_q;
  logic trig_done_q;
  logic gate_q;
  logic prohib_s1_q;
  logic prohib_q;
  logic prohib_d1_q;
  logic [31:0] ptag_q;
  logic drange_hold_q;
  logic was_tracing_q;
  logic [3:0] gap_q;
  sync_state_t sync_q;
  logic [3:0] exc_q;
  logic [NUM_EXTOUT-1:0] ext_q;
  logic trig_q;
  logic [15:0] cyc_q;

  logic hold;
  logic [127:0] res;
  logic trig_hit;
  logic gate_hit;
  logic view_hit;
  logic [NUM_EXTOUT-1:0] ext_hit;
  logic wr_en;
  logic rd_en;
  logic prohib_enter;
  logic tracing_c;

  assign hold = ctrl_q[CTRL_HOLD];

  // prohibit pin crosses in from another domain; entry may lag it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prohib_s1_q <= 1'b0;
      prohib_q <= 1'b0;
      prohib_d1_q <= 1'b0;
    end else begin
      prohib_s1_q <= prohibit_pin;
      prohib_q <= prohib_s1_q;
      prohib_d1_q <= prohib_q;
    end
  end
  assign prohib_enter = prohib_q & ~prohib_d1_q;

  // resource vector with the prohibited resource in its slot
  always_comb begin
    res = resources_in;
    res[RES_PROHIBITED] = prohib_q;
  end

  trace_event_unit u_trig (.resources(res), .cfg(trigger_ev_cfg), .hit(trig_hit));
  trace_event_unit u_gate (.resources(res), .cfg(gate_ev_cfg), .hit(gate_hit));
  trace_event_unit u_view (.resources(res), .cfg(view_ev_cfg), .hit(view_hit));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXTOUT; gi++) begin : g_ext
      trace_event_unit u_ext (
        .resources(res),
        .cfg(extout_cfg_q[gi*17 +: 17]),
        .hit(ext_hit[gi])
      );
    end
  endgenerate

  // apb: zero wait states, no errors
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      fifo_lvl_q <= FIFO_LVL_RESET;
      extout_cfg_q <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL: ctrl_q <= pwdata;
        OFF_FIFO_LVL: fifo_lvl_q <= pwdata[7:0];
        OFF_EXTOUT_EV: extout_cfg_q <= (NUM_EXTOUT*17)'(pwdata);
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        OFF_CTRL: prdata <= ctrl_q;
        OFF_STATUS: prdata <= {26'h000_0000, cycle_tick & 1'b0, prohib_q, gate_q,
                               tracing_c, trig_done_q, hold};
        OFF_FIFO_LVL: prdata <= {24'h00_0000, fifo_lvl_q};
        OFF_PTAG: prdata <= ptag_q;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // trigger: one per run, emitted the cycle after the event is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_done_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (hold) begin
        trig_done_q <= 1'b0;
      end else if (trig_hit && !trig_done_q) begin
        trig_q <= 1'b1;
        trig_done_q <= 1'b1;
      end
    end
  end
  assign trigger_out = trig_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= '0;
    end else begin
      ext_q <= hold ? '0 : ext_hit;
    end
  end
  assign ext_out = ext_q;

  // trace gate: rises anytime, falls at a boundary with no data pending, or anytime under hold or data-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
    end else if (hold) begin
      gate_q <= 1'b0;
    end else if (gate_hit) begin
      gate_q <= 1'b1;
    end else if (ctrl_q[CTRL_DATA_ONLY] || (instr_boundary && !data_outstanding)) begin
      gate_q <= 1'b0;
    end
  end
  assign trace_gate = gate_q;

  always_comb begin
    tracing_c = gate_q & ~debug_state & ~buffer_overflow & ~prohib_q;
    if (ctrl_q[CTRL_WFX_PROHIB]) begin
      tracing_c = tracing_c & ~wait_for_interrupt_state & ~wait_for_event_state;
    end
  end

  // short gaps are bridged on tracing, though the sync sequencer still restarts after a blip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 4'h0;
      was_tracing_q <= 1'b0;
    end else begin
      was_tracing_q <= tracing_c;
      if (tracing_c) begin
        gap_q <= 4'h0;
      end else if (gap_q != 4'hF) begin
        gap_q <= gap_q + 4'h1;
      end
    end
  end
  // gate, wait and overflow gaps are bridged; prohibition and debug always stop at once
  assign tracing = tracing_c | (was_tracing_q & ~prohib_q & ~debug_state
                   & (gap_q < 4'(MIN_GAP_CYCLES)));

  assign data_view_gate = view_hit & gate_q;
  assign data_trace_en = data_view_gate & tracing
                         & ~(ctrl_q[CTRL_SUPP_EN] & (buffer_level > fifo_lvl_q));
  assign ooo_data_en = ooo_data_return;

  // sync sequencer: address then tag on restart, branch-to-zero on prohibited entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= SYNC_IDLE;
      exc_q <= 4'h0;
      ptag_q <= 32'h0000_0000;
    end else begin
      case (sync_q)
        SYNC_IDLE: begin
          if (tracing_c && !was_tracing_q) begin
            sync_q <= SYNC_ADDR;
          end
        end
        SYNC_ADDR: sync_q <= ctrl_q[CTRL_PTAG_EN] ? SYNC_PTAG : SYNC_IDLE;
        SYNC_PTAG: sync_q <= SYNC_IDLE;
        SYNC_PROHIB: sync_q <= SYNC_IDLE;
        default: sync_q <= SYNC_IDLE;
      endcase
      // entry wins over a restart beat still in flight, so no entry is lost
      if (prohib_enter) begin
        sync_q <= SYNC_PROHIB;
        exc_q <= exception_entry ? exception_type : 4'h0;
      end
      // new tags seen on entry are withheld until prohibition ends
      if (!prohib_q) begin
        ptag_q <= process_tag_in;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_valid <= 1'b0;
      sync_kind <= SYNC_IDLE;
      sync_payload <= 32'h0000_0000;
      sync_exc <= 4'h0;
      sync_hyp <= 1'b0;
    end else begin
      sync_valid <= (sync_q != SYNC_IDLE);
      sync_kind <= sync_q;
      sync_hyp <= 1'b0;
      sync_exc <= (sync_q == SYNC_PROHIB) ? exc_q : 4'h0;
      case (sync_q)
        SYNC_ADDR: sync_payload <= instr_addr;
        SYNC_PTAG: sync_payload <= ptag_q;
        SYNC_PROHIB: sync_payload <= PROHIB_TARGET;
        default: sync_payload <= 32'h0000_0000;
      endcase
    end
  end

  // range match seen just before entry is held for the region
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drange_hold_q <= 1'b0;
    end else if (!prohib_q) begin
      drange_hold_q <= drange_match_raw;
    end
  end
  assign iaddr_match = iaddr_match_raw & ~prohib_q;
  assign daddr_match = daddr_match_raw & ~prohib_q;
  assign drange_match = prohib_q ? drange_hold_q : drange_match_raw;
  assign ptag_match = ptag_match_raw & ~prohib_q;
  assign instrument_fire = instrument_req & ~prohib_q;
  assign nonsecure_res = nonsecure_in & ~prohib_q;

  // cycle counter is not gated by prohibition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 16'h0000;
    end else if (sync_q == SYNC_ADDR) begin
      cyc_q <= 16'h0000;
    end else if (ctrl_q[CTRL_CYC_EN] && cycle_tick) begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end
  assign cycle_count = cyc_q;

  AST_EXT_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    $past(hold) |-> ext_out == '0) else $error("ext out high under hold");
  AST_ONE_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    trig_done_q |=> !trigger_out) else $error("second trigger");
  AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_out |-> trig_done_q) else $error("done flag not set");
  AST_VIEW: assert property (@(posedge pclk) disable iff (!presetn)
    data_view_gate |-> trace_gate) else $error("view without gate");
  AST_PROHIB_TRACE: assert property (@(posedge pclk) disable iff (!presetn)
    prohib_q |-> !tracing) else $error("tracing while prohibited");
  AST_PKT: assert property (@(posedge pclk) disable iff (!presetn)
    prohib_enter |-> ##2 (sync_valid && sync_kind == SYNC_PROHIB
    && sync_payload == PROHIB_TARGET && !sync_hyp)) else $error("no entry branch");
  AST_IMATCH: assert property (@(posedge pclk) disable iff (!presetn)
    prohib_q |-> !iaddr_match && !ptag_match) else $error("match in region");
  AST_GATE_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(trace_gate) && !$past(hold) && !$past(ctrl_q[CTRL_DATA_ONLY])
    |-> $past(instr_boundary)) else $error("gate fell mid instruction");
endmodule

// File: tb/trace_capture_model.sv
// Purpose: behavioural trace capture device listening on the trace port
// Assumes: each sync_valid pulse carries one beat; trigger_out is a one-cycle pulse
// Notes: cnt[0] counts triggers, cnt[1..3] count beats of that sync_kind
`timescale 1ns/1ps
module trace_capture_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger_out,
  input wire logic sync_valid,
  input wire logic [1:0] sync_kind,
  input wire logic [31:0] sync_payload,
  input wire logic [3:0] sync_exc,
  input wire logic sync_hyp,
  output logic [3:0][15:0] cnt,
  output logic [3:0][31:0] pay,
  output logic [3:0] exc_q,
  output logic hyp_q
);
  // the trigger may land between beats, so it is counted apart from them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      pay <= '0;
      exc_q <= 4'h0;
      hyp_q <= 1'b0;
    end else begin
      if (trigger_out) begin
        cnt[0] <= cnt[0] + 16'h0001;
      end
      if (sync_valid) begin
        cnt[sync_kind] <= cnt[sync_kind] + 16'h0001;
        pay[sync_kind] <= sync_payload;
        exc_q <= sync_exc;
        hyp_q <= sync_hyp;
      end
    end
  end
endmodule

// File: tb/trace_trigger_filter_control_test.sv
// Purpose: self-checking bench for the trace trigger and filter control block
// Assumes: zero-wait APB slave, capture model on the trace port
// Notes: random stimulus from a fixed-seed lfsr, corner cases written by hand
`timescale 1ns/1ps
module trace_trigger_filter_control_test;
  import trace_ctl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, instr_addr = 32'h0000_1000;
  logic [31:0] process_tag_in = 32'h0000_0abc, sync_payload, seed = 32'h0000_2662, r;
  logic [127:0] resources_in = '0;
  logic [16:0] trigger_ev_cfg = 17'h0_0000, gate_ev_cfg = {3'h0, 7'h08, 7'h08};
  logic [16:0] view_ev_cfg = {3'h0, 7'h09, 7'h09};
  logic instr_boundary = 1'b1, data_outstanding = 1'b0, debug_state = 1'b0;
  logic wait_for_interrupt_state = 1'b0, wait_for_event_state = 1'b0;
  logic buffer_overflow = 1'b0, prohibit_pin = 1'b0, nonsecure_in = 1'b0;
  logic exception_entry = 1'b0, iaddr_match_raw = 1'b0, daddr_match_raw = 1'b0;
  logic drange_match_raw = 1'b0, ptag_match_raw = 1'b0, instrument_req = 1'b0;
  logic ooo_data_return = 1'b0, cycle_tick = 1'b0, exp_tr;
  logic [7:0] buffer_level = 8'h00, lv, bl;
  logic [3:0] exception_type = 4'h0, ext_out, sync_exc, exc_q;
  logic pready, pslverr, trigger_out, tracing, trace_gate, data_view_gate, data_trace_en;
  logic ooo_data_en, sync_valid, sync_hyp, iaddr_match, daddr_match, drange_match;
  logic ptag_match, instrument_fire, nonsecure_res, hyp_q;
  logic [1:0] sync_kind;
  logic [15:0] cycle_count, cc0, n0, n1, n2, n3;
  logic [3:0][15:0] cnt;
  logic [3:0][31:0] pay;
  int err_total = 0, check_count = 0, cycles = 0;
  localparam logic [31:0] RUN_CTRL = (32'h0000_0001 << CTRL_PTAG_EN)
    | (32'h0000_0001 << CTRL_SUPP_EN) | (32'h0000_0001 << CTRL_CYC_EN)
    | (32'h0000_0001 << CTRL_WFX_PROHIB);

  trace_filter_ctl #(.NUM_EXTOUT(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .resources_in, .trigger_ev_cfg,
    .gate_ev_cfg, .view_ev_cfg, .instr_boundary, .data_outstanding, .debug_state,
    .wait_for_interrupt_state, .wait_for_event_state, .buffer_overflow, .buffer_level,
    .prohibit_pin, .nonsecure_in, .exception_entry, .exception_type, .instr_addr,
    .process_tag_in, .iaddr_match_raw, .daddr_match_raw, .drange_match_raw,
    .ptag_match_raw, .instrument_req, .ooo_data_return, .cycle_tick, .trigger_out,
    .ext_out, .tracing, .trace_gate, .data_view_gate, .data_trace_en, .ooo_data_en,
    .sync_valid, .sync_kind, .sync_payload, .sync_exc, .sync_hyp, .iaddr_match,
    .daddr_match, .drange_match, .ptag_match, .instrument_fire, .nonsecure_res,
    .cycle_count);
  trace_capture_model u_tcm (.pclk, .presetn, .trigger_out, .sync_valid, .sync_kind,
    .sync_payload, .sync_exc, .sync_hyp, .cnt, .pay, .exc_q, .hyp_q);

  always #5 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // an and of one resource with itself is that resource alone
  function automatic logic [16:0] ev(input logic [6:0] n);
    return {3'h0, n, n};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // idle edge after release so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(r, CTRL_RESET);
    apb(1'b0, OFF_FIFO_LVL, 32'h0000_0000);
    chk(r, {24'h00_0000, FIFO_LVL_RESET});
    apb(1'b1, 12'h020, seed);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    resources_in[7] <= 1'b1;
    apb(1'b1, OFF_EXTOUT_EV, {15'h0000, ev(7'h07)});
    cyc(3);
    chk(ext_out, 4'h0);
    apb(1'b1, OFF_CTRL, RUN_CTRL);
    cyc(3);
    chk(ext_out[0], 1'b1);
    instr_addr <= lfsr(seed);
    n1 = cnt[1];
    n2 = cnt[2];
    resources_in[8] <= 1'b1;
    cyc(8);
    chk(tracing, 1'b1);
    chk(cnt[1] - n1, 16'h0001);
    chk(pay[1], lfsr(seed));
    chk(cnt[2] - n2, 16'h0001);
    chk(pay[2], process_tag_in);
    // trigger held active: still a single pulse per run
    n0 = cnt[0];
    n1 = cnt[1];
    trigger_ev_cfg <= ev(7'h05);
    resources_in[5] <= 1'b1;
    cyc(12);
    chk(cnt[0] - n0, 16'h0001);
    chk(tracing, 1'b1);
    chk(cnt[1] - n1, 16'h0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r[1], 1'b1);
    apb(1'b1, OFF_CTRL, RUN_CTRL | 32'h0000_0001);
    cyc(1);
    chk(ext_out, 4'h0);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r[1], 1'b0);
    apb(1'b1, OFF_CTRL, RUN_CTRL);
    cyc(12);
    chk(cnt[0] - n0, 16'h0002);
    resources_in[5] <= 1'b0;
    cyc(8);
    lv = {1'b0, seed[6:0]};
    apb(1'b1, OFF_FIFO_LVL, {24'h00_0000, lv});
    apb(1'b0, OFF_FIFO_LVL, 32'h0000_0000);
    chk(r, {24'h00_0000, lv});
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      bl = (i == 0) ? lv : (i == 1) ? lv + 8'h01 : seed[23:16];
      debug_state <= seed[0] & seed[1];
      wait_for_interrupt_state <= seed[2] & seed[3];
      wait_for_event_state <= seed[4] & seed[5];
      buffer_overflow <= seed[6] & seed[7];
      resources_in[9] <= seed[8];
      buffer_level <= bl;
      cyc(5);
      exp_tr = !(|(seed[7:0] & {1'b0, seed[7:1]} & 8'h55));
      chk(tracing, exp_tr);
      chk(data_view_gate, seed[8]);
      chk(data_trace_en, exp_tr & seed[8] & (bl <= lv));
    end
    debug_state <= 1'b0;
    wait_for_interrupt_state <= 1'b0;
    wait_for_event_state <= 1'b0;
    buffer_overflow <= 1'b0;
    instr_boundary <= 1'b0;
    resources_in[8] <= 1'b0;
    resources_in[9] <= 1'b1;
    cyc(4);
    chk(trace_gate, 1'b1);
    instr_boundary <= 1'b1;
    cyc(3);
    chk(trace_gate, 1'b0);
    chk(data_view_gate, 1'b0);
    // data-only mode lets the gate drop away from an instruction boundary
    instr_boundary <= 1'b0;
    resources_in[8] <= 1'b1;
    apb(1'b1, OFF_CTRL, RUN_CTRL | (32'h0000_0001 << CTRL_DATA_ONLY));
    resources_in[8] <= 1'b0;
    cyc(3);
    chk(trace_gate, 1'b0);
    apb(1'b1, OFF_CTRL, RUN_CTRL);
    instr_boundary <= 1'b1;
    resources_in[8] <= 1'b1;
    {iaddr_match_raw, daddr_match_raw, drange_match_raw, ptag_match_raw} <= 4'hf;
    nonsecure_in <= 1'b1;
    cycle_tick <= 1'b1;
    apb(1'b1, OFF_EXTOUT_EV, {15'h0000, ev(RES_PROHIBITED)});
    cyc(4);
    chk(iaddr_match, 1'b1);
    chk(ext_out[0], 1'b0);
    cc0 = cycle_count;
    n2 = cnt[2];
    n3 = cnt[3];
    exception_entry <= 1'b1;
    exception_type <= seed[3:0];
    process_tag_in <= ~process_tag_in;
    prohibit_pin <= 1'b1;
    cyc(6);
    {drange_match_raw, instrument_req, data_outstanding, ooo_data_return} <= 4'h7;
    cyc(2);
    chk(cnt[3] - n3, 16'h0001);
    chk(pay[3], PROHIB_TARGET);
    chk(exc_q, seed[3:0]);
    chk(hyp_q, 1'b0);
    chk(cnt[2] - n2, 16'h0000);
    chk(tracing, 1'b0);
    chk(iaddr_match, 1'b0);
    chk(daddr_match, 1'b0);
    chk(drange_match, 1'b1);
    chk(ptag_match, 1'b0);
    chk(instrument_fire, 1'b0);
    chk(nonsecure_res, 1'b0);
    chk(ooo_data_en, 1'b1);
    chk(cycle_count != cc0, 1'b1);
    chk(ext_out[0], 1'b1);
    prohibit_pin <= 1'b0;
    exception_entry <= 1'b0;
    cyc(10);
    chk(tracing, 1'b1);
    give_verdict();
  end
endmodule
